// file: uart_irda_pkg.sv
/*
 * Shared constants and carriers for the serial port with IrDA mode,
 * mode-change settling, FIFO reset, halt/resume and DMA request gating.
 * Assumes a single 50 MHz core clock and byte-addressed 32-bit registers.
 */
package uart_irda_pkg;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [5:0] OFS_DATA   = 6'h00;
   localparam logic [5:0] OFS_MODE   = 6'h04;
   localparam logic [5:0] OFS_FIFO   = 6'h08;
   localparam logic [5:0] OFS_SUPP   = 6'h0C;
   localparam logic [5:0] OFS_MASK   = 6'h10;
   localparam logic [5:0] OFS_STATUS = 6'h14;
   localparam logic [5:0] OFS_PEND   = 6'h18;
   localparam logic [5:0] OFS_RESUME = 6'h1C;
   localparam logic [5:0] OFS_SYSCFG = 6'h20;
   localparam logic [5:0] OFS_LEVEL  = 6'h24;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int RX_CLR          = 0;
   localparam int TX_CLR          = 1;
   localparam int DMA_EN_BIT      = 3;
   localparam int THR_LSB         = 4;
   localparam int DMA_SEL         = 0;
   localparam int EXT_LSB         = 1;
   localparam int SOFT_RESET      = 1;
   localparam int IRQ_RX_DATA     = 0;
   localparam int IRQ_RX_TIMEOUT  = 1;
   localparam int IRQ_TX_EMPTY    = 2;
   localparam int IRQ_HALT        = 3;
   localparam int LEVEL_TX_LSB    = 8;

   // ---------------------------------------------------------------
   // protocol select encodings and timing
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_UART = 2'h0;
   localparam logic [1:0] MODE_IRDA = 2'h1;
   localparam logic [1:0] MODE_OFF  = 2'h3;

   localparam int CLK_HZ          = 50_000_000;
   localparam int BAUD_DEFAULT    = 115_200;
   localparam int CLKS_PER_BIT    = CLK_HZ / BAUD_DEFAULT;
   localparam int BITS_PER_CHAR   = 10;
   localparam int TIMEOUT_CHARS   = 4;
   localparam int RX_TIMEOUT_CYC  = TIMEOUT_CHARS * BITS_PER_CHAR
                                    * CLKS_PER_BIT;
   // both settle terms count on core_clk since both clocks are one here
   localparam int BUS_SETTLE_CYC  = 5;
   localparam int FUNC_SETTLE_CYC = 5;
   localparam logic [3:0] SETTLE_CYC = 4'(BUS_SETTLE_CYC + FUNC_SETTLE_CYC);

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LINE_IDLE  = 2'b00,
      LINE_START = 2'b01,
      LINE_DATA  = 2'b11,
      LINE_STOP  = 2'b10
   } line_state_e;

   typedef struct packed {
      logic [1:0] mode;
      logic       dma_bit;
      logic [3:0] rx_thr;
      logic       dma_sel;
      logic [1:0] dma_ext;
      logic [3:0] mask;
      logic [3:0] status;
      logic       halted;
      logic [3:0] settle;
   } ctrl_s;

   typedef struct packed {
      line_state_e st;
      logic [2:0]  bitn;
      logic [15:0] div;
      logic [7:0]  shift;
   } line_s;

   localparam logic [3:0] THR_RESET = 4'h1;
   localparam ctrl_s CTRL_RESET = '{mode: MODE_OFF, dma_bit: 1'b0,
      rx_thr: THR_RESET, dma_sel: 1'b0, dma_ext: 2'h0, mask: 4'h0,
      status: 4'h0, halted: 1'b0, settle: 4'h0};
   localparam line_s LINE_RESET = '{st: LINE_IDLE, bitn: 3'h0,
      div: 16'h0000, shift: 8'h00};

endpackage : uart_irda_pkg

// file: uart_irda_port.sv
/*
 * Serial port with UART and IrDA framing, Avalon-MM register slave,
 * sticky interrupt status, DMA request lines and power-management idle
 * handshake. Assumes uart_rx and idle_req are synchronous to core_clk.
 */
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps

// Operation
// - the pending flag reads 1 when no interrupt is pending and 0 otherwise.
// - clearing the receive-data enable masks receive-data and timeout irqs.
// - clearing the FIFOs through the FIFO control register resets their levels; a transmit clear is lost if a frame starts in that cycle.
// - reading the resume register releases a halted transfer.
// - the FIFO control register holds a DMA request enable bit.
// - DMA is on for select 1 with nonzero extended mode, else by that bit.
// - writing 1 to the soft reset bit resets the port so idle can be acked.
module uart_irda_port #(
   parameter int AW             = 4,
   parameter int CLKS_PER_BIT   = uart_irda_pkg::CLKS_PER_BIT,
   parameter int RX_TIMEOUT_CYC = uart_irda_pkg::RX_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // register bus
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // serial line
   input  wire logic        uart_rx,
   output logic             uart_tx,
   // system
   output logic             irq,
   output logic             rx_dma_req,
   output logic             tx_dma_req,
   input  wire logic        idle_req,
   output logic             idle_ack
);

   localparam int DEPTH = 1 << AW;

   function automatic logic [AW:0] level(input logic [AW:0] wp,
                                         input logic [AW:0] rp);
      level = wp - rp;
   endfunction : level

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   uart_irda_pkg::ctrl_s c_reg, c_next;
   uart_irda_pkg::line_s tx_reg, tx_next, rx_reg, rx_next;
   logic [AW:0]  rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;
   logic [AW:0]  tx_wp_reg, tx_wp_next, tx_rp_reg, tx_rp_next;
   logic [15:0]  to_reg, to_next;
   logic [31:0]  rdata_reg, rdata_next;
   logic         ack_reg, ack_next;
   logic         txo_reg, txo_next;
   logic         idle_ack_reg, idle_ack_next;
   logic [7:0]   rx_mem [DEPTH];
   logic [7:0]   tx_mem [DEPTH];

   logic         bus_req, fire_wr, fire_rd, tx_push, rx_push, run, dma_en;
   logic         rx_line, tx_bit;
   logic [AW:0]  rx_lvl, tx_lvl;
   logic [3:0]   eff_mask;
   logic [31:0]  rv;

   // ---------------------------------------------------------------
   // combinational decode shared with the ports
   // ---------------------------------------------------------------
   assign bus_req  = avs_read | avs_write;
   assign fire_wr  = avs_write & ack_reg;
   assign fire_rd  = avs_read & ack_reg;
   assign rx_lvl   = level(rx_wp_reg, rx_rp_reg);
   assign tx_lvl   = level(tx_wp_reg, tx_rp_reg);
   assign dma_en   = c_reg.dma_sel ? (c_reg.dma_ext != 2'h0)
                                   : c_reg.dma_bit;
   // receive-data enable also gates the timeout source
   assign eff_mask = {c_reg.mask[3:2], c_reg.mask[1] & c_reg.mask[0],
                      c_reg.mask[0]};
   assign irq      = |(c_reg.status & eff_mask);
   // engines start no new frame while the protocol select settles
   assign run      = (c_reg.mode != uart_irda_pkg::MODE_OFF)
                     & (c_reg.settle == 4'h0)
                     & ~(c_reg.halted
                         & (c_reg.mode == uart_irda_pkg::MODE_IRDA));
   // irda receive sees an active-high pulse for a zero bit; pulses are
   // assumed to cover the mid-bit sample point
   assign rx_line  = (c_reg.mode == uart_irda_pkg::MODE_IRDA) ? ~uart_rx
                                                               : uart_rx;
   assign rx_dma_req = dma_en & (rx_lvl != '0)
                       & (rx_lvl >= (AW+1)'(c_reg.rx_thr));
   assign tx_dma_req = dma_en & (tx_lvl != (AW+1)'(DEPTH));
   assign avs_waitrequest = bus_req & ~ack_reg;
   assign avs_readdata = rdata_reg;
   assign uart_tx  = txo_reg;
   assign idle_ack = idle_ack_reg;

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      c_next      = c_reg;
      tx_next     = tx_reg;
      rx_next     = rx_reg;
      rx_wp_next  = rx_wp_reg;
      rx_rp_next  = rx_rp_reg;
      tx_wp_next  = tx_wp_reg;
      tx_rp_next  = tx_rp_reg;
      to_next     = to_reg;
      rdata_next  = rdata_reg;
      ack_next    = bus_req & ~ack_reg;
      tx_push     = 1'b0;
      rx_push     = 1'b0;
      tx_bit      = 1'b1;
      rv          = 32'h0000_0000;
      if (c_reg.settle != 4'h0) begin
         c_next.settle = c_reg.settle - 4'h1;
      end

      // register read mux, sampled in the first cycle of the access
      unique case (avs_address)
         uart_irda_pkg::OFS_DATA:   rv[7:0] = rx_mem[rx_rp_reg[AW-1:0]];
         uart_irda_pkg::OFS_MODE:   rv[1:0] = c_reg.mode;
         uart_irda_pkg::OFS_FIFO: begin
            rv[uart_irda_pkg::DMA_EN_BIT] = c_reg.dma_bit;
            rv[uart_irda_pkg::THR_LSB +: 4] = c_reg.rx_thr;
         end
         uart_irda_pkg::OFS_SUPP: begin
            rv[uart_irda_pkg::DMA_SEL] = c_reg.dma_sel;
            rv[uart_irda_pkg::EXT_LSB +: 2] = c_reg.dma_ext;
         end
         uart_irda_pkg::OFS_MASK:   rv[3:0] = c_reg.mask;
         uart_irda_pkg::OFS_STATUS: rv[3:0] = c_reg.status;
         uart_irda_pkg::OFS_PEND:   rv[0] = ~irq;
         uart_irda_pkg::OFS_LEVEL: begin
            rv[AW:0] = rx_lvl;
            rv[uart_irda_pkg::LEVEL_TX_LSB +: (AW+1)] = tx_lvl;
         end
         default:                   rv = 32'h0000_0000;
      endcase
      if (avs_read & ~ack_reg) begin
         rdata_next = rv;
      end

      // side effects land on the edge where waitrequest is low
      if (fire_rd && avs_address == uart_irda_pkg::OFS_DATA
          && rx_lvl != '0) begin
         rx_rp_next = rx_rp_reg + 1'b1;
         to_next    = 16'h0000;
      end
      if (fire_rd && avs_address == uart_irda_pkg::OFS_RESUME) begin
         c_next.halted = 1'b0;
      end
      if (fire_wr) begin
         unique case (avs_address)
            uart_irda_pkg::OFS_DATA: begin
               tx_push = tx_lvl != (AW+1)'(DEPTH);
            end
            uart_irda_pkg::OFS_MODE: begin
               // glitch-prone write: hold off new frames, halt irda until resume
               c_next.mode   = avs_writedata[1:0];
               c_next.settle = uart_irda_pkg::SETTLE_CYC;
               c_next.halted = 1'b1;
            end
            uart_irda_pkg::OFS_FIFO: begin
               c_next.dma_bit = avs_writedata[uart_irda_pkg::DMA_EN_BIT];
               c_next.rx_thr  = avs_writedata[uart_irda_pkg::THR_LSB +: 4];
               if (avs_writedata[uart_irda_pkg::RX_CLR]) begin
                  rx_rp_next = rx_wp_reg;
                  to_next    = 16'h0000;
               end
               if (avs_writedata[uart_irda_pkg::TX_CLR]) begin
                  tx_rp_next = tx_wp_reg;
               end
            end
            uart_irda_pkg::OFS_SUPP: begin
               c_next.dma_sel = avs_writedata[uart_irda_pkg::DMA_SEL];
               c_next.dma_ext = avs_writedata[uart_irda_pkg::EXT_LSB +: 2];
            end
            uart_irda_pkg::OFS_MASK:   c_next.mask = avs_writedata[3:0];
            uart_irda_pkg::OFS_STATUS: begin
               c_next.status = c_reg.status & ~avs_writedata[3:0];
            end
            default: ;
         endcase
      end
      if (tx_push) begin
         tx_wp_next = tx_wp_reg + 1'b1;
      end

      // transmitter
      tx_next.div = tx_reg.div + 16'h0001;
      unique case (tx_reg.st)
         uart_irda_pkg::LINE_IDLE: begin
            tx_next.div = 16'h0000;
            if (run && tx_lvl != '0) begin
               tx_next.shift = tx_mem[tx_rp_reg[AW-1:0]];
               tx_next.st    = uart_irda_pkg::LINE_START;
               tx_rp_next    = tx_rp_reg + 1'b1;
            end
         end
         uart_irda_pkg::LINE_START: begin
            tx_bit = 1'b0;
            if (tx_reg.div == 16'(CLKS_PER_BIT - 1)) begin
               tx_next.div  = 16'h0000;
               tx_next.bitn = 3'h0;
               tx_next.st   = uart_irda_pkg::LINE_DATA;
            end
         end
         uart_irda_pkg::LINE_DATA: begin
            tx_bit = tx_reg.shift[0];
            if (tx_reg.div == 16'(CLKS_PER_BIT - 1)) begin
               tx_next.div   = 16'h0000;
               tx_next.shift = {1'b0, tx_reg.shift[7:1]};
               tx_next.bitn  = tx_reg.bitn + 3'h1;
               if (tx_reg.bitn == 3'h7) begin
                  tx_next.st = uart_irda_pkg::LINE_STOP;
               end
            end
         end
         uart_irda_pkg::LINE_STOP: begin
            if (tx_reg.div == 16'(CLKS_PER_BIT - 1)) begin
               tx_next.st = uart_irda_pkg::LINE_IDLE;
               if (tx_lvl == '0) begin
                  c_next.status[uart_irda_pkg::IRQ_TX_EMPTY] = 1'b1;
               end
            end
         end
      endcase
      // irda sends a 3/16-bit high pulse for each zero bit
      if (c_reg.mode == uart_irda_pkg::MODE_IRDA) begin
         txo_next = ~tx_bit & (tx_reg.div < 16'((CLKS_PER_BIT * 3) / 16));
      end else begin
         txo_next = tx_bit;
      end

      // receiver, started half a bit in so later samples land mid-bit
      rx_next.div = rx_reg.div + 16'h0001;
      unique case (rx_reg.st)
         uart_irda_pkg::LINE_IDLE: begin
            rx_next.div = 16'h0000;
            if (run && !rx_line) begin
               rx_next.st = uart_irda_pkg::LINE_START;
            end
         end
         uart_irda_pkg::LINE_START: begin
            if (rx_reg.div == 16'(CLKS_PER_BIT / 2)) begin
               rx_next.div  = 16'h0000;
               rx_next.bitn = 3'h0;
               rx_next.st   = rx_line ? uart_irda_pkg::LINE_IDLE
                                      : uart_irda_pkg::LINE_DATA;
            end
         end
         uart_irda_pkg::LINE_DATA: begin
            if (rx_reg.div == 16'(CLKS_PER_BIT - 1)) begin
               rx_next.div   = 16'h0000;
               rx_next.shift = {rx_line, rx_reg.shift[7:1]};
               rx_next.bitn  = rx_reg.bitn + 3'h1;
               if (rx_reg.bitn == 3'h7) begin
                  rx_next.st = uart_irda_pkg::LINE_STOP;
               end
            end
         end
         uart_irda_pkg::LINE_STOP: begin
            if (rx_reg.div == 16'(CLKS_PER_BIT - 1)) begin
               rx_next.st = uart_irda_pkg::LINE_IDLE;
               // framing errors and overruns drop the byte silently
               rx_push = rx_line & (rx_lvl != (AW+1)'(DEPTH));
            end
         end
      endcase
      if (rx_push) begin
         rx_wp_next = rx_wp_reg + 1'b1;
         to_next    = 16'h0000;
         c_next.status[uart_irda_pkg::IRQ_RX_DATA] = 1'b1;
      end else if (rx_lvl != '0 && to_reg != 16'(RX_TIMEOUT_CYC - 1)) begin
         to_next = to_reg + 16'h0001;
      end else if (rx_lvl != '0) begin
         c_next.status[uart_irda_pkg::IRQ_RX_TIMEOUT] = 1'b1;
      end
      if (c_reg.halted & ~c_next.halted) begin
         c_next.status[uart_irda_pkg::IRQ_HALT] = 1'b1;
      end

      idle_ack_next = idle_req & ~dma_en & (tx_lvl == '0)
                      & (tx_reg.st == uart_irda_pkg::LINE_IDLE)
                      & (rx_reg.st == uart_irda_pkg::LINE_IDLE);

      if (fire_wr && avs_address == uart_irda_pkg::OFS_SYSCFG
          && avs_writedata[uart_irda_pkg::SOFT_RESET]) begin
         c_next     = uart_irda_pkg::CTRL_RESET;
         tx_next    = uart_irda_pkg::LINE_RESET;
         rx_next    = uart_irda_pkg::LINE_RESET;
         rx_wp_next = '0;
         rx_rp_next = '0;
         tx_wp_next = '0;
         tx_rp_next = '0;
         to_next    = 16'h0000;
         tx_push    = 1'b0;
         rx_push    = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         c_reg        <= uart_irda_pkg::CTRL_RESET;
         tx_reg       <= uart_irda_pkg::LINE_RESET;
         rx_reg       <= uart_irda_pkg::LINE_RESET;
         rx_wp_reg    <= '0;
         rx_rp_reg    <= '0;
         tx_wp_reg    <= '0;
         tx_rp_reg    <= '0;
         to_reg       <= 16'h0000;
         rdata_reg    <= 32'h0000_0000;
         ack_reg      <= 1'b0;
         txo_reg      <= 1'b1;
         idle_ack_reg <= 1'b0;
      end else begin
         c_reg        <= c_next;
         tx_reg       <= tx_next;
         rx_reg       <= rx_next;
         rx_wp_reg    <= rx_wp_next;
         rx_rp_reg    <= rx_rp_next;
         tx_wp_reg    <= tx_wp_next;
         tx_rp_reg    <= tx_rp_next;
         to_reg       <= to_next;
         rdata_reg    <= rdata_next;
         ack_reg      <= ack_next;
         txo_reg      <= txo_next;
         idle_ack_reg <= idle_ack_next;
      end
   end

   // fifo storage carries no reset; pointers decide what is valid
   always_ff @(posedge core_clk) begin
      if (tx_push) begin
         tx_mem[tx_wp_reg[AW-1:0]] <= avs_writedata[7:0];
      end
      if (rx_push) begin
         rx_mem[rx_wp_reg[AW-1:0]] <= rx_reg.shift;
      end
   end

endmodule : uart_irda_port

// file: uart_line_echo.sv
/* far end of the serial line: a cable looped from transmit to receive.
   assumes the port's core_clk and rst */
`timescale 1ns/100ps
module uart_line_echo (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // serial line
   input  wire logic tx_line,
   output logic      rx_line
);
   // one flop of cable delay; idle high so reset looks like a quiet line
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) rx_line <= 1'b1;
      else     rx_line <= tx_line;
   end
endmodule : uart_line_echo

// file: uart_irda_port_asserts.sv
/* checker for the port's bus, interrupt, dma and idle pins.
   bound to uart_irda_port; one clock domain */
`timescale 1ns/100ps
module uart_irda_port_asserts (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // register bus
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // system
   input wire logic        irq,
   input wire logic        rx_dma_req,
   input wire logic        tx_dma_req,
   input wire logic        idle_req,
   input wire logic        idle_ack
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic rd_done;
   logic wr_done;
   assign rd_done = avs_read & ~avs_waitrequest;
   assign wr_done = avs_write & ~avs_waitrequest;
   property p_first_wait;
      $rose(avs_read | avs_write) |-> avs_waitrequest;
   endproperty
   property p_one_wait;
      (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_wait_req;
      avs_waitrequest |-> (avs_read || avs_write);
   endproperty
   property p_pend;
      rd_done && avs_address == uart_irda_pkg::OFS_PEND
         |-> avs_readdata[0] == !$past(irq);
   endproperty
   property p_resume_zero;
      rd_done && avs_address == uart_irda_pkg::OFS_RESUME
         |-> avs_readdata == 32'h0;
   endproperty
   property p_ack_req;
      idle_ack |-> $past(idle_req);
   endproperty
   property p_ack_dma;
      tx_dma_req |=> !idle_ack;
   endproperty
   property p_soft_idle;
      (wr_done && avs_address == uart_irda_pkg::OFS_SYSCFG && avs_writedata[1])
         ##1 idle_req [*2] |=> idle_ack;
   endproperty
   property p_rx_clear;
      wr_done && avs_address == uart_irda_pkg::OFS_FIFO && avs_writedata[0]
         |=> !rx_dma_req;
   endproperty
   a_first_wait: assert property (p_first_wait)
      else $error("no wait state on new request");
   a_one_wait: assert property (p_one_wait)
      else $error("more than one wait state");
   a_wait_req: assert property (p_wait_req)
      else $error("waitrequest without request");
   a_pend: assert property (p_pend)
      else $error("pending flag not inverse of irq");
   a_resume_zero: assert property (p_resume_zero)
      else $error("resume read not zero");
   a_ack_req: assert property (p_ack_req)
      else $error("idle ack without idle request");
   a_ack_dma: assert property (p_ack_dma)
      else $error("idle ack while dma enabled");
   a_soft_idle: assert property (p_soft_idle)
      else $error("no idle ack after soft reset");
   a_rx_clear: assert property (p_rx_clear)
      else $error("rx dma request after fifo clear");
   c_rx_dma: cover property ($rose(rx_dma_req));
   c_idle: cover property ($rose(idle_ack));
   c_irq: cover property ($rose(irq));
endmodule : uart_irda_port_asserts

bind uart_irda_port uart_irda_port_asserts u_asserts (
   .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_readdata, .avs_waitrequest, .irq, .rx_dma_req, .tx_dma_req,
   .idle_req, .idle_ack
);

// file: tb_uart_irda_mode_switch_dma.sv
/* self-checking bench for uart_irda_port with a looped serial line.
   assumes short bit and timeout counts set at the instance */
`timescale 1ns/100ps
module tb_uart_irda_mode_switch_dma;
   logic        core_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        uart_rx, uart_tx, irq, rx_dma_req, tx_dma_req;
   logic        idle_req, idle_ack;
   int          n_mismatch, checks;
   uart_irda_port #(.CLKS_PER_BIT(8), .RX_TIMEOUT_CYC(200)) u_dut (
      .core_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .uart_rx,
      .uart_tx, .irq, .rx_dma_req, .tx_dma_req, .idle_req, .idle_ack);
   uart_line_echo u_line (.core_clk, .rst, .tx_line(uart_tx),
      .rx_line(uart_rx));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ---------------------------------------------------------------
   // bus and compare helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // request rises after an edge and holds until waitrequest is low
   task automatic bus(input logic is_wr, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= is_wr;
      avs_read <= ~is_wr;
      // values read right after the edge are the ones the slave sampled
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] e,
                     input string w);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e, w);
   endtask : rd
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd(uart_irda_pkg::OFS_PEND, 32'h1, "pend at reset");
      rd(uart_irda_pkg::OFS_MODE, 32'h3, "mode at reset");
      rd(6'h3C, 32'h0, "unmapped");
   endtask : t_reset
   task automatic t_mode(input logic [1:0] m);
      wr(uart_irda_pkg::OFS_FIFO, 32'h10);
      wr(uart_irda_pkg::OFS_SUPP, 32'h0);
      wr(uart_irda_pkg::OFS_MODE, {30'h0, m});
      repeat (10) @(posedge core_clk);
      wr(uart_irda_pkg::OFS_FIFO, 32'h13);
   endtask : t_mode
   // uart mode runs with no resume read
   task automatic t_loop;
      int n;
      wr(uart_irda_pkg::OFS_MASK, 32'h1);
      wr(uart_irda_pkg::OFS_DATA, 32'hA5);
      for (n = 0; n < 300 && irq !== 1'b1; n++) @(negedge core_clk);
      chk(irq, 1'b1, "irq after echo");
      repeat (20) @(posedge core_clk);
      rd(uart_irda_pkg::OFS_STATUS, 32'h5, "status rx");
      rd(uart_irda_pkg::OFS_PEND, 32'h0, "pend set");
      rd(uart_irda_pkg::OFS_DATA, 32'hA5, "rx byte");
      wr(uart_irda_pkg::OFS_STATUS, 32'hF);
      rd(uart_irda_pkg::OFS_PEND, 32'h1, "pend clear");
   endtask : t_loop
   // timeout enable alone must not pass a timeout
   task automatic t_gate;
      wr(uart_irda_pkg::OFS_MASK, 32'h2);
      wr(uart_irda_pkg::OFS_DATA, 32'h3C);
      repeat (400) @(posedge core_clk);
      rd(uart_irda_pkg::OFS_STATUS, 32'h7, "status timeout");
      @(negedge core_clk);
      chk(irq, 1'b0, "irq gated");
      wr(uart_irda_pkg::OFS_MASK, 32'h1);
      @(negedge core_clk);
      chk(irq, 1'b1, "irq ungated");
      rd(uart_irda_pkg::OFS_DATA, 32'h3C, "rx byte two");
      wr(uart_irda_pkg::OFS_STATUS, 32'hF);
   endtask : t_gate
   task automatic t_dma;
      wr(uart_irda_pkg::OFS_FIFO, 32'h2B);
      @(negedge core_clk);
      chk(tx_dma_req, 1'b1, "tx dma on");
      wr(uart_irda_pkg::OFS_DATA, 32'h11);
      repeat (100) @(negedge core_clk);
      chk(rx_dma_req, 1'b0, "rx dma below threshold");
      wr(uart_irda_pkg::OFS_DATA, 32'h22);
      repeat (100) @(negedge core_clk);
      chk(rx_dma_req, 1'b1, "rx dma at threshold");
      wr(uart_irda_pkg::OFS_SUPP, 32'h1);
      @(negedge core_clk);
      chk(tx_dma_req, 1'b0, "select with mode zero");
      wr(uart_irda_pkg::OFS_SUPP, 32'h3);
      idle_req <= 1'b1;
      repeat (5) @(negedge core_clk);
      chk(tx_dma_req, 1'b1, "select with mode one");
      chk(idle_ack, 1'b0, "idle refused");
      wr(uart_irda_pkg::OFS_FIFO, 32'h23);
      rd(uart_irda_pkg::OFS_LEVEL, 32'h0, "levels cleared");
      wr(uart_irda_pkg::OFS_SYSCFG, 32'h2);
      repeat (3) @(negedge core_clk);
      chk(idle_ack, 1'b1, "idle after soft reset");
      rd(uart_irda_pkg::OFS_MODE, 32'h3, "mode after soft reset");
      idle_req <= 1'b0;
   endtask : t_dma
   task automatic t_irda;
      int          hi;
      logic [31:0] q;
      t_mode(uart_irda_pkg::MODE_IRDA);
      wr(uart_irda_pkg::OFS_DATA, 32'h55);
      hi = 0;
      repeat (60) begin
         @(negedge core_clk);
         if (uart_tx !== 1'b0) hi++;
      end
      chk(hi, 0, "tx while halted");
      rd(uart_irda_pkg::OFS_RESUME, 32'h0, "resume");
      repeat (120) begin
         @(negedge core_clk);
         if (uart_tx === 1'b1) hi++;
      end
      chk(hi != 0, 1'b1, "tx after resume");
      bus(1'b0, uart_irda_pkg::OFS_STATUS, 32'h0, q);
      chk(q[uart_irda_pkg::IRQ_HALT], 1'b1, "halt released");
   endtask : t_irda
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   // a full pass takes about 1000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      give_verdict;
   end
   initial begin
      rst = 1'b1;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      idle_req = 1'b0;
      n_mismatch = 0;
      checks = 0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_mode(uart_irda_pkg::MODE_UART);
      t_loop;
      t_gate;
      t_dma;
      t_irda;
      give_verdict;
   end
endmodule : tb_uart_irda_mode_switch_dma
